/* File: core/hcw_pkg.sv */
package hcw_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 50;
    // Shortest time element; longer ones are whole multiples of it
    localparam int BASE_US = 100;
    localparam int BASE_CYC = BASE_US * 1000 / CLK_NS;
    localparam int CAR_PERIOD_NS = 25000;
    localparam int CAR_HALF_CYC = CAR_PERIOD_NS / 2 / CLK_NS;

    // ------------------------------------------------------------
    // Word layout, in time elements and bits
    // ------------------------------------------------------------
    localparam logic [6:0] PRE_TE = 7'h17;
    localparam logic [6:0] HDR_TE = 7'h0A;
    localparam logic [6:0] BIT_TE = 7'h03;
    localparam logic [6:0] GUARD_TE = 7'h27;
    localparam logic [6:0] GUARD_EXT_TE = 7'h3A;
    localparam logic [6:0] CRC_FIRST_BIT = 7'h41;
    localparam logic [6:0] LAST_BIT = 7'h42;

    localparam logic [9:0] TMO_WORDS_SLOW = 10'h100;
    localparam logic [9:0] TMO_WORDS_FAST = 10'h200;
    localparam logic [9:0] DELAY_WORDS_SLOW = 10'h01C;
    localparam logic [9:0] DELAY_WORDS_FAST = 10'h038;

    localparam logic [3:0] CODE_SEED_NOW = 4'h9;
    localparam logic [3:0] CODE_SEED_LATE = 4'h3;
    localparam logic [3:0] CODE_B_FIRST = 4'h8;

    // ------------------------------------------------------------
    // Register map (byte addresses) and option bits
    // ------------------------------------------------------------
    localparam logic [4:0] REG_CONFIG = 5'h00;
    localparam logic [4:0] REG_SERIAL = 5'h04;
    localparam logic [4:0] REG_HOP = 5'h08;
    localparam logic [4:0] REG_SEED = 5'h0C;
    localparam logic [4:0] REG_SYNC_A = 5'h10;
    localparam logic [4:0] REG_SYNC_B = 5'h14;
    localparam logic [4:0] REG_PLAIN = 5'h18;
    localparam logic [4:0] REG_STATUS = 5'h1C;

    localparam int CFG_AUTO_OFF = 0;
    localparam int CFG_DUAL = 1;
    localparam int CFG_SKIP = 2;
    localparam int CFG_FMT = 3;
    localparam int CFG_RATE = 4;
    localparam int CFG_MOD = 5;
    localparam int CFG_LONG = 6;
    localparam int CFG_SEED = 7;
    localparam int CFG_USER = 8;
    localparam int CFG_WRAP = 10;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [15:0] CFG_WMASK = 16'h07FF;

    typedef enum logic [2:0] {
        HCW_IDLE = 3'h0,
        HCW_PRE = 3'h1,
        HCW_HDR = 3'h3,
        HCW_DATA = 3'h2,
        HCW_GUARD = 3'h6,
        HCW_TMO = 3'h7
    } hcw_state_t;

endpackage : hcw_pkg

/* File: core/hcw_transmitter.sv */
// How it works
// [R1] With auto shutoff on, timing out drives data low and lamp off.
// [R2] The timed-out state is left only once every button reads low.
// [R3] With auto shutoff off, words repeat without limit while held.
// [R4] Time-out limit is 256 words at slow rate, 512 at fast rate.
// [R5] Dual counter mode: codes 1-7 use counter A, codes 8-15 counter B.
// [R6] Without dual counter mode every code uses counter A.
// [R7] Infrared mode sends codes 8 to 15 on counter B.
// [R8] Infrared mode gates each high pulse with a 25 us carrier.
// [R9] Carrier is divided from the same clock as the bit timing.
// [R10] Seed enabled: code 9 sends seed at once, code 3 after delay.
// [R11] Word: preamble, header, encrypted, fixed data, then guard.
// [R12] Data part is 67 bits: 32 encrypted then 35 fixed.
// [R13] Cipher input holds buttons, user, wrap, mode, serial and sync.
// [R14] Clear part: 28-bit serial, 4 buttons, low battery, 2 check bits.
// [R15] Long serial mode sends 32 serial bits instead of buttons.
// [R16] A started word finishes unless a different button aborts it; then idle if no button is held.
// [R17] At least two words per activation, more while held.
// [R18] A different button aborts the word and starts a new one.
// [R19] Skip mode sends every second word and idles the slot between.
// [R20] Bit rate select picks the fast or slow time element.
// [R21] Check bits run serially over the first 65 bits from zero.
// [R22] Lamp is low while word data goes out and high in guard.
// [R23] All timing counts one clock in units of the time element.
//
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module hcw_transmitter #(
    parameter int BASE_CYC = hcw_pkg::BASE_CYC,
    parameter int CAR_HALF_CYC = hcw_pkg::CAR_HALF_CYC
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [3:0] buttonIn,
    input wire logic lowBatteryIn,
    output logic dataOut,
    output logic lampN
);

    typedef struct packed {
        hcw_pkg::hcw_state_t st;
        logic [3:0] b1;
        logic [3:0] b2;
        logic [3:0] b3;
        logic [3:0] btn;
        logic [2:0] lb;
        logic lowBat;
        logic [3:0] code;
        logic [10:0] baseCnt;
        logic [1:0] teDiv;
        logic [6:0] ph;
        logic [6:0] bitIdx;
        logic [66:0] frame;
        logic [1:0] crc;
        logic [7:0] carCnt;
        logic car;
        logic [9:0] words;
        logic blank;
        logic [15:0] syncA;
        logic [15:0] syncB;
        logic [15:0] cfg;
        logic [31:0] serial;
        logic [31:0] hop;
        logic [31:0] seed;
        logic [31:0] rdata;
        logic waitReq;
        logic dataOut;
        logic lampN;
    } hcw_regs_t;

    hcw_regs_t r_q;
    hcw_regs_t r_d;

    logic pulse;
    logic teTick;
    logic segEnd;
    logic startAct;
    logic startWord;
    logic curBit;
    logic [6:0] segLen;
    logic [3:0] wc;
    logic [9:0] wNext;
    logic [9:0] tmoLimit;
    logic [31:0] enc;
    logic [31:0] clr;
    logic [31:0] rd;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic use_b(input logic dual, input logic [3:0] c);
        use_b = dual && (c >= hcw_pkg::CODE_B_FIRST); // [R5] [R6] [R7]
    endfunction : use_b

    // Time element as a count of 100 us steps, minus one
    function automatic logic [1:0] te_div_max(input logic [15:0] c);
        if (c[hcw_pkg::CFG_MOD]) begin
            te_div_max = c[hcw_pkg::CFG_RATE] ? 2'h1 : 2'h3;
        end else if (c[hcw_pkg::CFG_FMT]) begin
            te_div_max = c[hcw_pkg::CFG_RATE] ? 2'h0 : 2'h1;
        end else begin
            te_div_max = c[hcw_pkg::CFG_RATE] ? 2'h1 : 2'h3;
        end
    endfunction : te_div_max

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] wd, input logic [3:0] be);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                merge[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
    endfunction : merge

    function automatic logic word_state(input hcw_pkg::hcw_state_t s);
        word_state = (s == hcw_pkg::HCW_PRE) || (s == hcw_pkg::HCW_HDR) ||
            (s == hcw_pkg::HCW_DATA) || (s == hcw_pkg::HCW_GUARD);
    endfunction : word_state

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        r_d = r_q;
        pulse = 1'b0;
        teTick = 1'b0;
        startAct = 1'b0;
        startWord = 1'b0;
        curBit = 1'b0;
        rd = 32'h0000_0000;

        // Pins: three stages, accepted once the last two agree
        r_d.b1 = buttonIn;
        r_d.b2 = r_q.b1;
        r_d.b3 = r_q.b2;
        if (r_q.b2 == r_q.b3) begin
            r_d.btn = r_q.b3;
        end
        r_d.lb = {r_q.lb[1:0], lowBatteryIn};
        if (r_q.lb[1] == r_q.lb[2]) begin
            r_d.lowBat = r_q.lb[2];
        end

        // Time element divider and carrier share sys_clk
        if (r_q.baseCnt == 11'(BASE_CYC - 1)) begin // [R23]
            r_d.baseCnt = 11'h000;
            if (r_q.teDiv == te_div_max(r_q.cfg)) begin // [R20]
                r_d.teDiv = 2'h0;
                teTick = 1'b1;
            end else begin
                r_d.teDiv = r_q.teDiv + 2'h1;
            end
        end else begin
            r_d.baseCnt = r_q.baseCnt + 11'h001;
        end
        if (r_q.carCnt == 8'(CAR_HALF_CYC - 1)) begin // [R9]
            r_d.carCnt = 8'h00;
            r_d.car = !r_q.car;
        end else begin
            r_d.carCnt = r_q.carCnt + 8'h01;
        end

        case (r_q.st)
            hcw_pkg::HCW_PRE: segLen = hcw_pkg::PRE_TE;
            hcw_pkg::HCW_HDR: segLen = hcw_pkg::HDR_TE;
            hcw_pkg::HCW_DATA: segLen = hcw_pkg::BIT_TE;
            default: segLen = r_q.cfg[hcw_pkg::CFG_MOD] ?
                hcw_pkg::GUARD_EXT_TE : hcw_pkg::GUARD_TE;
        endcase
        segEnd = teTick && (r_q.ph == segLen - 7'h01);
        if (teTick) begin
            r_d.ph = segEnd ? 7'h00 : r_q.ph + 7'h01;
        end
        tmoLimit = r_q.cfg[hcw_pkg::CFG_RATE] ?
            hcw_pkg::TMO_WORDS_FAST : hcw_pkg::TMO_WORDS_SLOW; // [R4]

        case (r_q.st)
            hcw_pkg::HCW_IDLE: begin
                startAct = (r_q.btn != 4'h0);
            end
            hcw_pkg::HCW_PRE: begin
                pulse = !r_q.ph[0];
                if (segEnd) begin
                    r_d.st = hcw_pkg::HCW_HDR; // [R11]
                end
            end
            hcw_pkg::HCW_HDR: begin
                if (segEnd) begin
                    r_d.st = hcw_pkg::HCW_DATA; // [R11]
                end
            end
            hcw_pkg::HCW_DATA: begin
                if (r_q.bitIdx == hcw_pkg::CRC_FIRST_BIT) begin
                    curBit = r_q.crc[1];
                end else if (r_q.bitIdx == hcw_pkg::LAST_BIT) begin
                    curBit = r_q.crc[0];
                end else begin
                    curBit = r_q.frame[r_q.bitIdx];
                end
                // One is a short high, zero a long high
                pulse = (r_q.ph == 7'h00) || (r_q.ph == 7'h01 && !curBit);
                if (segEnd) begin
                    if (r_q.bitIdx < hcw_pkg::CRC_FIRST_BIT) begin
                        r_d.crc[1] = r_q.crc[0] ^ curBit; // [R21]
                        r_d.crc[0] = r_q.crc[0] ^ curBit ^ r_q.crc[1];
                    end
                    if (r_q.bitIdx == hcw_pkg::LAST_BIT) begin
                        r_d.st = hcw_pkg::HCW_GUARD; // [R12]
                    end else begin
                        r_d.bitIdx = r_q.bitIdx + 7'h01;
                    end
                end
            end
            hcw_pkg::HCW_GUARD: begin
                if (segEnd) begin
                    r_d.words = r_q.words + 10'h001;
                    r_d.blank = r_q.cfg[hcw_pkg::CFG_SKIP] && !r_q.blank; // [R19]
                    if (r_q.cfg[hcw_pkg::CFG_AUTO_OFF] &&
                        r_d.words == tmoLimit) begin
                        r_d.st = hcw_pkg::HCW_TMO; // [R1] [R4]
                    end else if (r_q.btn != 4'h0 || r_q.words == 10'h000) begin
                        startWord = 1'b1; // [R3] [R17]
                    end else begin
                        r_d.st = hcw_pkg::HCW_IDLE; // [R16]
                    end
                end
            end
            hcw_pkg::HCW_TMO: begin
                if (r_q.btn == 4'h0) begin
                    r_d.st = hcw_pkg::HCW_IDLE; // [R2]
                end
            end
            default: r_d.st = hcw_pkg::HCW_IDLE;
        endcase

        // A release never aborts, only a different button does
        if (word_state(r_q.st) && r_q.btn != 4'h0 && r_q.btn != r_q.code) begin
            startAct = 1'b1; // [R18]
        end

        // ------------------------------------------------------------
        // Register bus: one wait cycle, write lands when it drops
        // ------------------------------------------------------------
        if (address == hcw_pkg::REG_CONFIG) begin
            rd = {16'h0000, r_q.cfg};
        end else if (address == hcw_pkg::REG_SERIAL) begin
            rd = r_q.serial;
        end else if (address == hcw_pkg::REG_HOP) begin
            rd = r_q.hop;
        end else if (address == hcw_pkg::REG_SEED) begin
            rd = r_q.seed;
        end else if (address == hcw_pkg::REG_SYNC_A) begin
            rd = {16'h0000, r_q.syncA};
        end else if (address == hcw_pkg::REG_SYNC_B) begin
            rd = {16'h0000, r_q.syncB};
        end else if (address == hcw_pkg::REG_PLAIN) begin
            rd = {r_q.code, r_q.cfg[hcw_pkg::CFG_USER +: 2],
                r_q.cfg[hcw_pkg::CFG_WRAP], r_q.cfg[hcw_pkg::CFG_DUAL],
                r_q.serial[7:0], use_b(r_q.cfg[hcw_pkg::CFG_DUAL], r_q.code) ?
                r_q.syncB : r_q.syncA}; // [R13]
        end else if (address == hcw_pkg::REG_STATUS) begin
            rd = {13'h0000, r_q.st, r_q.btn, r_q.blank, r_q.lowBat, r_q.words};
        end
        r_d.waitReq = 1'b1;
        if ((read || write) && r_q.waitReq) begin
            r_d.waitReq = 1'b0;
            r_d.rdata = read ? rd : 32'h0000_0000;
        end
        if (write && !r_q.waitReq) begin
            if (address == hcw_pkg::REG_CONFIG) begin
                r_d.cfg = 16'(merge({16'h0000, r_q.cfg}, writedata,
                    byteenable)) & hcw_pkg::CFG_WMASK;
            end else if (address == hcw_pkg::REG_SERIAL) begin
                r_d.serial = merge(r_q.serial, writedata, byteenable);
            end else if (address == hcw_pkg::REG_HOP) begin
                r_d.hop = merge(r_q.hop, writedata, byteenable);
            end else if (address == hcw_pkg::REG_SEED) begin
                r_d.seed = merge(r_q.seed, writedata, byteenable);
            end else if (address == hcw_pkg::REG_SYNC_A) begin
                r_d.syncA = 16'(merge({16'h0000, r_q.syncA}, writedata,
                    byteenable));
            end else if (address == hcw_pkg::REG_SYNC_B) begin
                r_d.syncB = 16'(merge({16'h0000, r_q.syncB}, writedata,
                    byteenable));
            end
        end

        // ------------------------------------------------------------
        // Word start; the counter step overrides a bus write
        // ------------------------------------------------------------
        wc = startAct ? r_q.btn : r_q.code;
        wNext = startAct ? 10'h000 : r_d.words;
        if (startAct) begin
            r_d.code = r_q.btn;
            r_d.words = 10'h000;
            r_d.blank = 1'b0;
            startWord = 1'b1;
            if (use_b(r_q.cfg[hcw_pkg::CFG_DUAL], r_q.btn)) begin
                r_d.syncB = r_q.syncB + 16'h0001; // [R5] [R7]
                if (r_q.syncB == 16'hFFFF) begin
                    r_d.cfg[hcw_pkg::CFG_WRAP] = 1'b0;
                end
            end else begin
                r_d.syncA = r_q.syncA + 16'h0001; // [R6]
                if (r_q.syncA == 16'hFFFF) begin
                    r_d.cfg[hcw_pkg::CFG_WRAP] = 1'b0;
                end
            end
        end
        if (r_q.cfg[hcw_pkg::CFG_SEED] && (wc == hcw_pkg::CODE_SEED_NOW ||
            (wc == hcw_pkg::CODE_SEED_LATE && wNext >= (r_q.cfg[
            hcw_pkg::CFG_RATE] ? hcw_pkg::DELAY_WORDS_FAST :
            hcw_pkg::DELAY_WORDS_SLOW)))) begin
            enc = r_q.seed; // [R10]
        end else begin
            enc = r_q.hop;
        end
        clr = r_q.cfg[hcw_pkg::CFG_LONG] ? r_q.serial :
            {wc, r_q.serial[27:0]}; // [R14] [R15]
        if (startWord) begin
            r_d.st = hcw_pkg::HCW_PRE; // [R11]
            r_d.ph = 7'h00;
            r_d.baseCnt = 11'h000;
            r_d.teDiv = 2'h0;
            r_d.bitIdx = 7'h00;
            r_d.crc = 2'h0; // [R21]
            r_d.frame = {2'h0, r_q.lowBat, clr, enc}; // [R12]
        end

        // Outputs are registered one cycle behind the state
        r_d.dataOut = pulse && !r_q.blank &&
            (!r_q.cfg[hcw_pkg::CFG_DUAL] || r_q.car); // [R8] [R19]
        r_d.lampN = !(word_state(r_q.st) && r_q.st != hcw_pkg::HCW_GUARD &&
            !r_q.blank); // [R22]
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            r_q <= '0;
            r_q.st <= hcw_pkg::HCW_IDLE;
            r_q.cfg <= hcw_pkg::CFG_RESET;
            r_q.waitReq <= 1'b1;
            r_q.lampN <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    assign readdata = r_q.rdata;
    assign waitrequest = r_q.waitReq;
    assign dataOut = r_q.dataOut;
    assign lampN = r_q.lampN;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    property p_tmo_quiet;
        r_q.st == hcw_pkg::HCW_TMO |=> !dataOut && lampN;
    endproperty
    a_tmo_quiet: assert property (p_tmo_quiet) else $error("timeout not quiet"); // [R1]

    property p_tmo_hold;
        r_q.st == hcw_pkg::HCW_TMO && r_q.btn != 4'h0 |=>
            r_q.st == hcw_pkg::HCW_TMO;
    endproperty
    a_tmo_hold: assert property (p_tmo_hold) else $error("left timeout early"); // [R2]

    property p_tmo_limit;
        r_q.st == hcw_pkg::HCW_GUARD && segEnd &&
            r_q.cfg[hcw_pkg::CFG_AUTO_OFF] && r_q.words == tmoLimit - 10'h001
            |=> r_q.st == hcw_pkg::HCW_TMO;
    endproperty
    a_tmo_limit: assert property (p_tmo_limit) else $error("no timeout"); // [R4]

    property p_cnt_a;
        startAct && !use_b(r_q.cfg[hcw_pkg::CFG_DUAL], r_q.btn) |=>
            r_q.syncA == $past(r_q.syncA) + 16'h0001 &&
            r_q.syncB == $past(r_q.syncB);
    endproperty
    a_cnt_a: assert property (p_cnt_a) else $error("counter A not used"); // [R6]

    property p_cnt_b;
        startAct && r_q.cfg[hcw_pkg::CFG_DUAL] && r_q.btn[3] |=>
            r_q.syncB == $past(r_q.syncB) + 16'h0001;
    endproperty
    a_cnt_b: assert property (p_cnt_b) else $error("counter B not used"); // [R5]

    property p_ir_gate;
        r_q.cfg[hcw_pkg::CFG_DUAL] && r_q.st == hcw_pkg::HCW_PRE &&
            !r_q.car && !r_q.blank |=> !dataOut;
    endproperty
    a_ir_gate: assert property (p_ir_gate) else $error("carrier not gating"); // [R8]

    property p_bit_range;
        r_q.st == hcw_pkg::HCW_DATA |-> r_q.bitIdx <= hcw_pkg::LAST_BIT;
    endproperty
    a_bit_range: assert property (p_bit_range) else $error("bit index overrun"); // [R12]

    property p_min_two;
        r_q.st == hcw_pkg::HCW_GUARD && segEnd && r_q.words == 10'h000 &&
            !startAct |=> r_q.st == hcw_pkg::HCW_PRE;
    endproperty
    a_min_two: assert property (p_min_two) else $error("second word lost"); // [R17]

    property p_abort;
        r_q.st == hcw_pkg::HCW_DATA && r_q.btn != 4'h0 &&
            r_q.btn != r_q.code |=> r_q.st == hcw_pkg::HCW_PRE &&
            r_q.code == $past(r_q.btn);
    endproperty
    a_abort: assert property (p_abort) else $error("no abort"); // [R18]

    property p_lamp;
        r_q.st == hcw_pkg::HCW_DATA && !r_q.blank ##1
            r_q.st == hcw_pkg::HCW_DATA |-> !lampN;
    endproperty
    a_lamp: assert property (p_lamp) else $error("lamp not on"); // [R22]

    property p_bus;
        (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
    endproperty
    a_bus: assert property (p_bus) else $error("bus answer late");

    c_timeout: cover property (r_q.st == hcw_pkg::HCW_TMO);
    c_abort: cover property (r_q.st == hcw_pkg::HCW_DATA && startAct);
    c_blank: cover property (r_q.blank && r_q.st == hcw_pkg::HCW_GUARD);
    c_seed: cover property (startWord && enc == r_q.seed &&
        r_q.cfg[hcw_pkg::CFG_SEED]);

endmodule : hcw_transmitter

`default_nettype wire

/* File: verification/hcw_rx_model.sv */
`timescale 1ns/10ps
`default_nettype none
module hcw_rx_model #(
    parameter int TE_CYC = 2000
) (
    input wire logic sys_clk,
    input wire logic dataOut,
    input wire logic lampN,
    output logic [66:0] wordBits,
    output logic [7:0] wordCount
);
    // Split between a one and a two element pulse
    localparam int SPLIT = TE_CYC * 3 / 2;
    logic [66:0] shiftQ;
    logic [15:0] highLen;
    logic dataQ;
    logic lampQ;
    initial begin
        wordCount = 8'h00;
        highLen = 16'h0000;
        dataQ = 1'b0;
        lampQ = 1'b1;
    end
    // Preamble pulses shift through and fall off; the last 67 remain
    always @(posedge sys_clk) begin
        dataQ <= dataOut;
        lampQ <= lampN;
        if (dataOut) begin
            highLen <= highLen + 16'h0001;
        end
        if (dataQ && !dataOut) begin
            shiftQ <= {highLen < SPLIT, shiftQ[66:1]};
            highLen <= 16'h0000;
        end
        if (!lampQ && lampN) begin
            wordBits <= shiftQ;
            wordCount <= wordCount + 8'h01;
        end
    end
endmodule : hcw_rx_model
`default_nettype wire

/* File: verification/hcw_transmitter_test.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin testsRun++; if ((g) !== (e)) begin errors++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module hcw_transmitter_test;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [4:0] address = 5'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic [3:0] buttonIn = 4'h0;
    logic lowBatteryIn = 1'b0;
    logic dataOut;
    logic lampN;
    logic [66:0] wordBits;
    logic [7:0] wordCount;
    logic [31:0] r;
    int errors = 0;
    int testsRun = 0;
    // Short time element keeps the run small; carrier keeps its ratio
    localparam int TE_CYC = 40;
    localparam int CAR_CYC = 5;
    always #25 sys_clk = ~sys_clk;
    hcw_transmitter #(.BASE_CYC(TE_CYC), .CAR_HALF_CYC(CAR_CYC))
        u_hcw_transmitter (.sys_clk(sys_clk), .rstn(rstn),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
        .waitrequest(waitrequest), .buttonIn(buttonIn),
        .lowBatteryIn(lowBatteryIn), .dataOut(dataOut), .lampN(lampN));
    hcw_rx_model #(.TE_CYC(TE_CYC)) u_hcw_rx_model (.sys_clk(sys_clk),
        .dataOut(dataOut),
        .lampN(lampN), .wordBits(wordBits), .wordCount(wordCount));
    // ------------------------------------------------------------
    // Bus and helpers
    // ------------------------------------------------------------
    task automatic busWr(input logic [4:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        address <= a;
        writedata <= d;
        write <= 1'b1;
        do @(posedge sys_clk); while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask : busWr
    task automatic busRd(input logic [4:0] a);
        @(posedge sys_clk);
        address <= a;
        read <= 1'b1;
        do @(posedge sys_clk); while (waitrequest !== 1'b0);
        r = readdata;
        read <= 1'b0;
    endtask : busRd
    task automatic doReset();
        buttonIn <= 4'h0;
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
    endtask : doReset
    // Press a code and wait until the word sequencer leaves idle
    task automatic startAct(input logic [3:0] c);
        buttonIn <= c;
        do busRd(hcw_pkg::REG_STATUS); while (r[18:16] === 3'h0);
    endtask : startAct
    // One word is 273 time elements
    task automatic waitWords(input logic [7:0] n);
        int i;
        for (i = 0; i < 12000 && wordCount != n; i++) @(posedge sys_clk);
        `CHK("words", n, wordCount)
    endtask : waitWords
    function automatic logic [66:0] mkWord(logic [31:0] lo, logic [31:0] hi,
            logic vb);
        logic [1:0] c;
        logic [64:0] b;
        b = {vb, hi, lo};
        c = 2'h0;
        for (int i = 0; i < 65; i++) c = {c[0] ^ b[i], c[0] ^ b[i] ^ c[1]};
        return {c[0], c[1], b};
    endfunction : mkWord
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic testRegs();
        busRd(hcw_pkg::REG_CONFIG);
        `CHK("config reset", 32'h0, r)
        busWr(hcw_pkg::REG_CONFIG, 32'hFFFF_FFFF);
        busRd(hcw_pkg::REG_CONFIG);
        `CHK("config mask", 32'h0000_07FF, r)
        busWr(hcw_pkg::REG_STATUS, 32'hFFFF_FFFF);
        busRd(hcw_pkg::REG_STATUS);
        `CHK("status ro", 32'h0, r)
        busRd(5'h02);
        `CHK("unmapped", 32'h0, r)
    endtask : testRegs
    task automatic testWord();
        logic [7:0] n;
        doReset();
        busWr(hcw_pkg::REG_CONFIG, 32'h0000_0018);
        busWr(hcw_pkg::REG_SERIAL, 32'hA5C3_0F17);
        busWr(hcw_pkg::REG_HOP, 32'h1234_5678);
        busWr(hcw_pkg::REG_SYNC_A, 32'h0000_FFFE);
        lowBatteryIn <= 1'b1;
        n = wordCount;
        startAct(4'h5);
        buttonIn <= 4'h0;
        repeat (4) @(posedge sys_clk);
        `CHK("lamp in word", 1'b0, lampN)
        waitWords(n + 8'h01);
        `CHK("lamp in guard", 1'b1, lampN)
        `CHK("word", mkWord(32'h1234_5678, 32'h5C3_0F17 | 32'h5000_0000, 1'b1), wordBits)
        waitWords(n + 8'h02);
        repeat (40 * TE_CYC) @(posedge sys_clk);
        busRd(hcw_pkg::REG_STATUS);
        `CHK("idle after two", 13'h0002, {r[18:16], r[9:0]})
        busRd(hcw_pkg::REG_SYNC_A);
        `CHK("sync a step", 32'h0000_FFFF, r)
        lowBatteryIn <= 1'b0;
    endtask : testWord
    task automatic testSkip();
        logic [7:0] n;
        doReset();
        busWr(hcw_pkg::REG_CONFIG, 32'h0000_001C);
        n = wordCount;
        startAct(4'h2);
        buttonIn <= 4'h0;
        waitWords(n + 8'h01);
        repeat (320 * TE_CYC) @(posedge sys_clk);
        busRd(hcw_pkg::REG_STATUS);
        `CHK("skip idle", 13'h0002, {r[18:16], r[9:0]})
        `CHK("skip count", n + 8'h01, wordCount)
    endtask : testSkip
    task automatic testCounters();
        doReset();
        busWr(hcw_pkg::REG_CONFIG, 32'h0000_0002);
        busWr(hcw_pkg::REG_SYNC_A, 32'h0000_0010);
        busWr(hcw_pkg::REG_SYNC_B, 32'h0000_0020);
        startAct(4'hC);
        busRd(hcw_pkg::REG_SYNC_B);
        `CHK("sync b", 32'h0000_0021, r)
        busRd(hcw_pkg::REG_SYNC_A);
        `CHK("sync a kept", 32'h0000_0010, r)
        buttonIn <= 4'h3;
        do busRd(hcw_pkg::REG_STATUS); while (r[15:12] !== 4'h3);
        repeat (4) @(posedge sys_clk);
        busRd(hcw_pkg::REG_SYNC_A);
        `CHK("abort restart", 32'h0000_0011, r)
        busRd(hcw_pkg::REG_STATUS);
        `CHK("abort count", 10'h000, r[9:0])
        doReset();
        startAct(4'hC);
        busRd(hcw_pkg::REG_SYNC_A);
        `CHK("single counter", 32'h0000_0001, r)
    endtask : testCounters
    task automatic testSeedLong();
        logic [7:0] n;
        doReset();
        busWr(hcw_pkg::REG_CONFIG, 32'h0000_00D8);
        busWr(hcw_pkg::REG_SERIAL, 32'h9ABC_DEF1);
        busWr(hcw_pkg::REG_HOP, 32'h1111_2222);
        busWr(hcw_pkg::REG_SEED, 32'h5EED_0042);
        n = wordCount;
        startAct(4'h9);
        buttonIn <= 4'h0;
        waitWords(n + 8'h01);
        `CHK("seed long", mkWord(32'h5EED_0042, 32'h9ABC_DEF1, 1'b0), wordBits)
    endtask : testSeedLong
    task automatic testIr();
        int len;
        doReset();
        busWr(hcw_pkg::REG_CONFIG, 32'h0000_001A);
        startAct(4'h1);
        len = 0;
        while (dataOut !== 1'b1 && len < 3000) begin
            @(posedge sys_clk);
            len++;
        end
        len = 0;
        while (dataOut === 1'b1 && len < 3000) begin
            @(posedge sys_clk);
            len++;
        end
        `CHK("carrier half", 1'b1, len > 0 && len <= CAR_CYC)
        doReset();
    endtask : testIr
    task automatic stopTest();
        if (errors == 0 && testsRun > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stopTest
    initial begin
        doReset();
        testRegs();
        testCounters();
        testIr();
        testSeedLong();
        testWord();
        testSkip();
        stopTest();
    end
    // Planned traffic is about 56000 cycles
    initial begin
        repeat (80000) @(posedge sys_clk);
        errors++;
        stopTest();
    end
endmodule : hcw_transmitter_test
`default_nettype wire
